//--- sfc_pkg.sv
// Constants, opcodes and state types of the serial flash command front end
package sfc_pkg;
	localparam int PAGE_BYTES = 32'h0000_0100;
	localparam int SUB_BYTES = 32'h0000_1000;
	localparam int SECT_BYTES = 32'h0001_0000;
	localparam int PAGES_LARGE = 32'h0000_0400;
	localparam int PAGES_SMALL = 32'h0000_0200;
	localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] LOCK_READ_VAL = 8'h00;
	localparam int STS_BUSY_BIT = 32'h0;
	localparam int STS_WPL_BIT = 32'h1;
	localparam logic [7:0] OPC_READ = 8'h03;
	localparam logic [7:0] OPC_FAST_READ = 8'h0B;
	localparam logic [7:0] OPC_STATUS_READ = 8'h05;
	localparam logic [7:0] OPC_PAGE_REWRITE = 8'h0A;
	localparam logic [7:0] OPC_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OPC_PAGE_WIPE = 8'hDB;
	localparam logic [7:0] OPC_SUB_WIPE = 8'h20;
	localparam logic [7:0] OPC_SECT_WIPE = 8'hD8;
	localparam logic [7:0] OPC_ALL_WIPE = 8'hC7;
	localparam logic [7:0] OPC_PERMIT_SET = 8'h06;
	localparam logic [7:0] OPC_PERMIT_CLEAR = 8'h04;
	localparam logic [7:0] OPC_STATUS_UPDATE = 8'h01;
	localparam logic [7:0] OPC_LOCK_UPDATE = 8'hE5;
	localparam logic [7:0] OPC_LOCK_READ = 8'hE8;
	localparam logic [7:0] OPC_SLEEP_ENTRY = 8'hB9;
	localparam logic [7:0] OPC_SLEEP_EXIT = 8'hAB;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_OPCODE = 3'b001,
		ST_ADDR = 3'b010,
		ST_DUMMY = 3'b011,
		ST_DATA_OUT = 3'b100,
		ST_DATA_IN = 3'b101,
		ST_TAIL = 3'b110,
		ST_IGNORE = 3'b111
	} sfc_cmd_st_e;

	typedef enum logic [1:0] {
		EX_IDLE = 2'b00,
		EX_PAGE = 2'b01,
		EX_FILL = 2'b10
	} sfc_exec_st_e;
endpackage : sfc_pkg

//--- sfc_link_if.sv
// Byte-level link between the serial shifter and the command core
`timescale 1ns/1ps
interface sfc_link_if;
	logic rx_stb;
	logic [7:0] rx_byte;
	logic sel;
	logic sel_start;
	logic sel_end;
	logic boundary;
	logic [7:0] tx_byte;
	modport shifter (output rx_stb, rx_byte, sel, sel_start, sel_end,
		boundary, input tx_byte);
	modport core (input rx_stb, rx_byte, sel, sel_start, sel_end,
		boundary, output tx_byte);
endinterface : sfc_link_if

//--- sfc_shifter.sv
// Pin synchroniser and bit shifter for the serial flash link
`timescale 1ns/1ps
module sfc_shifter (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic sck_pin,
	input wire logic csn_pin,
	input wire logic sdi_pin,
	output logic sdo,
	sfc_link_if.shifter lk
);
	logic sck_s1_ff, sck_s2_ff, sck_s3_ff;
	logic csn_s1_ff, csn_s2_ff, csn_s3_ff;
	logic sdi_s1_ff, sdi_s2_ff;
	logic [2:0] bit_cnt_ff;
	logic [7:0] rx_sh_ff;
	logic [7:0] tx_sh_ff;
	logic rx_stb_ff;
	logic [7:0] rx_byte_ff;
	logic sdo_ff;
	logic rise;
	logic fall;
	logic first_ff;

	// Stage one feeds only stage two; edges are judged on stages two/three
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sck_s1_ff <= 1'b0;
			sck_s2_ff <= 1'b0;
			sck_s3_ff <= 1'b0;
			csn_s1_ff <= 1'b1;
			csn_s2_ff <= 1'b1;
			csn_s3_ff <= 1'b1;
			sdi_s1_ff <= 1'b0;
			sdi_s2_ff <= 1'b0;
		end else if (ce) begin
			sck_s1_ff <= sck_pin;
			sck_s2_ff <= sck_s1_ff;
			sck_s3_ff <= sck_s2_ff;
			csn_s1_ff <= csn_pin;
			csn_s2_ff <= csn_s1_ff;
			csn_s3_ff <= csn_s2_ff;
			sdi_s1_ff <= sdi_pin;
			sdi_s2_ff <= sdi_s1_ff;
		end
	end

	assign lk.sel = !csn_s2_ff;
	assign lk.sel_start = csn_s3_ff && !csn_s2_ff;
	assign lk.sel_end = !csn_s3_ff && csn_s2_ff;
	assign rise = lk.sel && sck_s2_ff && !sck_s3_ff;
	assign fall = lk.sel && !sck_s2_ff && sck_s3_ff;
	assign lk.boundary = (bit_cnt_ff == 3'h0);
	assign lk.rx_stb = rx_stb_ff;
	assign lk.rx_byte = rx_byte_ff;
	assign sdo = sdo_ff;

	// Input bits land on rising edges, first one right after select
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bit_cnt_ff <= 3'h0;
			rx_sh_ff <= 8'h00;
			rx_stb_ff <= 1'b0;
			rx_byte_ff <= 8'h00;
		end else if (ce) begin
			rx_stb_ff <= rise && (bit_cnt_ff == 3'h7);
			if (lk.sel_start) begin
				bit_cnt_ff <= 3'h0;
			end else if (rise) begin
				bit_cnt_ff <= bit_cnt_ff + 3'h1;
				rx_sh_ff <= {rx_sh_ff[6:0], sdi_s2_ff};
				rx_byte_ff <= {rx_sh_ff[6:0], sdi_s2_ff};
			end
		end
	end

	// Output bits change on falling edges; a new byte loads at the boundary
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_sh_ff <= 8'h00;
			sdo_ff <= 1'b0;
		end else if (ce && fall) begin
			if (lk.boundary) begin
				sdo_ff <= lk.tx_byte[7];
				tx_sh_ff <= {lk.tx_byte[6:0], 1'b0};
			end else begin
				sdo_ff <= tx_sh_ff[7];
				tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
			end
		end
	end

	// Marks a frame still waiting for its first rising edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			first_ff <= 1'b0;
		end else if (ce) begin
			if (lk.sel_start) begin
				first_ff <= 1'b1;
			end else if (rise || !lk.sel) begin
				first_ff <= 1'b0;
			end
		end
	end

	AST_MSB_IN: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		rise && !lk.sel_start |=>
		rx_sh_ff == {$past(rx_sh_ff[6:0]), $past(sdi_s2_ff)})
		else $error("input bit not shifted in msb first");
	AST_MSB_OUT: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		fall && lk.boundary |=> sdo_ff == $past(lk.tx_byte[7]))
		else $error("output byte did not start with its msb");
	AST_FIRST_EDGE: assert property (
		@(posedge clk) disable iff (!rstn || !ce)
		first_ff && rise && !lk.sel_start |=>
		bit_cnt_ff == 3'h1 && rx_sh_ff[0] == $past(sdi_s2_ff))
		else $error("first rising edge after select not captured");
endmodule : sfc_shifter

//--- sfc_front_end.sv
// Serial flash command front end with page array and wipe/program engine
// Summary of operation
// - Large variant: 1024 pages of 256 bytes.
// - Small variant: 512 pages of 256 bytes.
// - Subsector is 4096 aligned bytes.
// - Sector is 65536 aligned bytes, sixteen subsectors.
// - Program only clears bits to zero.
// - Wipe sets every addressed bit to one.
// - Page rewrite stores supplied values exactly.
// - All serial bytes travel MSB first.
// - Input captured from first rising edge on.
// - Opcode byte first, then per-command bytes.
// - Read commands output until host deselects.
// - Modifying commands need byte-boundary deselect.
// - Array access ignored while internal cycle runs.
// - 03h array read; 05h status read.
// - 0Bh fast read with one dummy byte.
// - 0Ah page rewrite, 1 to 256 bytes.
// - 02h program, DBh page, 20h subsector wipe.
// - D8h sector, C7h whole wipe, 06h permit set.
// - 04h permit clear; 01h status update.
// - E5h lock update, E8h lock read.
// - B9h sleep entry, ABh sleep exit.
// - Modifying commands need write permit latch set.
`timescale 1ns/1ps
module sfc_front_end #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic CE,
	input wire logic SCK,
	input wire logic CS_N,
	input wire logic SDI,
	output logic SDO,
	output logic SDO_OE,
	output logic BUSY,
	output logic WRITE_PERMIT,
	output logic SLEEPING
);
	localparam int PAGES = LARGE_VARIANT ? sfc_pkg::PAGES_LARGE :
		sfc_pkg::PAGES_SMALL;
	localparam int MEM_BYTES = PAGES * sfc_pkg::PAGE_BYTES;
	localparam int AW = $clog2(MEM_BYTES);

	function automatic logic [AW-1:0] align_to(input logic [AW-1:0] a,
		input int span);
		align_to = a & ~AW'(span - 1);
	endfunction : align_to

	function automatic logic [AW:0] span_of(input int span);
		span_of = (AW+1)'(span);
	endfunction : span_of

	sfc_link_if lk();
	sfc_pkg::sfc_cmd_st_e state_ff;
	sfc_pkg::sfc_cmd_st_e nxt_after_opc;
	sfc_pkg::sfc_cmd_st_e nxt_after_addr;
	sfc_pkg::sfc_exec_st_e ex_state_ff;
	logic [7:0] mem [MEM_BYTES];
	logic [7:0] page_buf [sfc_pkg::PAGE_BYTES];
	logic [sfc_pkg::PAGE_BYTES-1:0] page_mask_ff;
	logic [7:0] col_ff;
	logic [7:0] opc_ff;
	logic [23:0] addr_ff;
	logic [23:0] nxt_addr;
	logic [1:0] acnt_ff;
	logic got_data_ff;
	logic [7:0] tx_ff;
	logic out_en_ff;
	logic wpl_ff;
	logic sleep_ff;
	logic [AW-1:0] ex_ptr_ff;
	logic [AW:0] ex_left_ff;
	logic ex_rewrite_ff;
	logic busy;
	logic ex_done;
	logic ex_we;
	logic [7:0] ex_old;
	logic [7:0] ex_new;
	logic [7:0] status_byte;
	logic is_tail;
	logic is_data;
	logic wpl_ok;
	logic wpl_set;
	logic wpl_clr;
	logic sleep_set;
	logic sleep_clr;
	logic start_page;
	logic start_fill;
	logic [AW-1:0] fill_base;
	logic [AW:0] fill_span;

	sfc_shifter u_shifter (
		.clk(CLK_SYS),
		.rstn(RSTN),
		.ce(CE),
		.sck_pin(SCK),
		.csn_pin(CS_N),
		.sdi_pin(SDI),
		.sdo(SDO),
		.lk(lk)
	);

	assign lk.tx_byte = tx_ff;
	assign busy = (ex_state_ff != sfc_pkg::EX_IDLE);
	assign ex_done = busy && (ex_left_ff == (AW+1)'(1));
	assign nxt_addr = {addr_ff[15:0], lk.rx_byte};
	assign SDO_OE = out_en_ff;
	assign BUSY = busy;
	assign WRITE_PERMIT = wpl_ff;
	assign SLEEPING = sleep_ff;

	always_comb begin
		status_byte = 8'h00;
		status_byte[sfc_pkg::STS_WPL_BIT] = wpl_ff;
		status_byte[sfc_pkg::STS_BUSY_BIT] = busy;
	end

	// Byte counts after the opcode; in sleep only the exit code is heard
	always_comb begin
		case (lk.rx_byte)
		sfc_pkg::OPC_READ, sfc_pkg::OPC_FAST_READ,
		sfc_pkg::OPC_PAGE_REWRITE, sfc_pkg::OPC_PAGE_PROGRAM,
		sfc_pkg::OPC_PAGE_WIPE, sfc_pkg::OPC_SUB_WIPE,
		sfc_pkg::OPC_SECT_WIPE,
		sfc_pkg::OPC_LOCK_UPDATE, sfc_pkg::OPC_LOCK_READ: begin
			nxt_after_opc = sfc_pkg::ST_ADDR;
		end
		sfc_pkg::OPC_STATUS_READ: begin
			nxt_after_opc = sfc_pkg::ST_DATA_OUT;
		end
		sfc_pkg::OPC_STATUS_UPDATE: begin
			nxt_after_opc = sfc_pkg::ST_DATA_IN;
		end
		sfc_pkg::OPC_ALL_WIPE, sfc_pkg::OPC_PERMIT_SET,
		sfc_pkg::OPC_PERMIT_CLEAR,
		sfc_pkg::OPC_SLEEP_ENTRY, sfc_pkg::OPC_SLEEP_EXIT: begin
			nxt_after_opc = sfc_pkg::ST_TAIL;
		end
		default: begin
			nxt_after_opc = sfc_pkg::ST_IGNORE;
		end
		endcase
		if (sleep_ff && lk.rx_byte != sfc_pkg::OPC_SLEEP_EXIT) begin
			nxt_after_opc = sfc_pkg::ST_IGNORE;
		end
	end

	// Reads of the array are refused outright while a cycle runs
	always_comb begin
		case (opc_ff)
		sfc_pkg::OPC_READ: begin
			nxt_after_addr = busy ? sfc_pkg::ST_IGNORE :
				sfc_pkg::ST_DATA_OUT;
		end
		sfc_pkg::OPC_FAST_READ: begin
			nxt_after_addr = busy ? sfc_pkg::ST_IGNORE :
				sfc_pkg::ST_DUMMY;
		end
		sfc_pkg::OPC_LOCK_READ: begin
			nxt_after_addr = sfc_pkg::ST_DATA_OUT;
		end
		sfc_pkg::OPC_PAGE_REWRITE, sfc_pkg::OPC_PAGE_PROGRAM,
		sfc_pkg::OPC_LOCK_UPDATE: begin
			nxt_after_addr = sfc_pkg::ST_DATA_IN;
		end
		default: begin
			nxt_after_addr = sfc_pkg::ST_TAIL;
		end
		endcase
	end

	// Command sequencer: one step per received byte
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			state_ff <= sfc_pkg::ST_IDLE;
			opc_ff <= 8'h00;
			addr_ff <= 24'h00_0000;
			acnt_ff <= 2'h0;
			got_data_ff <= 1'b0;
			tx_ff <= 8'h00;
			out_en_ff <= 1'b0;
		end else if (CE) begin
			if (lk.sel_start) begin
				state_ff <= sfc_pkg::ST_OPCODE;
				acnt_ff <= 2'h0;
				got_data_ff <= 1'b0;
				out_en_ff <= 1'b0;
			end else if (lk.sel_end) begin
				state_ff <= sfc_pkg::ST_IDLE;
				out_en_ff <= 1'b0;
			end else if (lk.rx_stb) begin
				case (state_ff)
				sfc_pkg::ST_OPCODE: begin
					opc_ff <= lk.rx_byte;
					state_ff <= nxt_after_opc;
					if (nxt_after_opc == sfc_pkg::ST_DATA_OUT) begin
						tx_ff <= status_byte;
						out_en_ff <= 1'b1;
					end
				end
				sfc_pkg::ST_ADDR: begin
					addr_ff <= nxt_addr;
					acnt_ff <= acnt_ff + 2'h1;
					if (acnt_ff == sfc_pkg::LAST_ADDR_BYTE) begin
						state_ff <= nxt_after_addr;
						if (nxt_after_addr == sfc_pkg::ST_DATA_OUT) begin
							out_en_ff <= 1'b1;
							if (opc_ff == sfc_pkg::OPC_LOCK_READ) begin
								tx_ff <= sfc_pkg::LOCK_READ_VAL;
							end else begin
								tx_ff <= mem[nxt_addr[AW-1:0]];
								addr_ff <= nxt_addr + 24'h00_0001;
							end
						end
					end
				end
				sfc_pkg::ST_DUMMY: begin
					state_ff <= sfc_pkg::ST_DATA_OUT;
					out_en_ff <= 1'b1;
					tx_ff <= mem[addr_ff[AW-1:0]];
					addr_ff <= addr_ff + 24'h00_0001;
				end
				sfc_pkg::ST_DATA_OUT: begin
					if (opc_ff == sfc_pkg::OPC_STATUS_READ) begin
						tx_ff <= status_byte;
					end else if (opc_ff == sfc_pkg::OPC_LOCK_READ) begin
						tx_ff <= sfc_pkg::LOCK_READ_VAL;
					end else begin
						tx_ff <= mem[addr_ff[AW-1:0]];
						addr_ff <= addr_ff + 24'h00_0001;
					end
				end
				sfc_pkg::ST_DATA_IN: begin
					got_data_ff <= 1'b1;
					// Single-byte updates reject a second data byte
					if (got_data_ff && (opc_ff == sfc_pkg::OPC_STATUS_UPDATE ||
						opc_ff == sfc_pkg::OPC_LOCK_UPDATE)) begin
						state_ff <= sfc_pkg::ST_IGNORE;
					end
				end
				sfc_pkg::ST_TAIL: begin
					state_ff <= sfc_pkg::ST_IGNORE;
				end
				default: begin
					state_ff <= state_ff;
				end
				endcase
			end
		end
	end

	// Page buffer is frozen while a cycle runs so a new frame cannot
	// corrupt the data being committed
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			page_mask_ff <= '0;
			col_ff <= 8'h00;
		end else if (CE && !busy) begin
			if (lk.sel_start) begin
				page_mask_ff <= '0;
			end else if (lk.rx_stb && state_ff == sfc_pkg::ST_ADDR) begin
				col_ff <= lk.rx_byte;
			end else if (lk.rx_stb && state_ff == sfc_pkg::ST_DATA_IN) begin
				page_mask_ff[col_ff] <= 1'b1;
				col_ff <= col_ff + 8'h01;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (CE && !busy && lk.rx_stb && state_ff == sfc_pkg::ST_DATA_IN) begin
			page_buf[col_ff] <= lk.rx_byte;
		end
	end

	// Deselect decides: only at a byte boundary does anything execute
	assign is_tail = (state_ff == sfc_pkg::ST_TAIL);
	assign is_data = (state_ff == sfc_pkg::ST_DATA_IN) && got_data_ff;
	assign wpl_ok = wpl_ff && !busy;

	always_comb begin
		wpl_set = 1'b0;
		wpl_clr = 1'b0;
		sleep_set = 1'b0;
		sleep_clr = 1'b0;
		start_page = 1'b0;
		start_fill = 1'b0;
		fill_base = align_to(addr_ff[AW-1:0], sfc_pkg::PAGE_BYTES);
		fill_span = span_of(sfc_pkg::PAGE_BYTES);
		if (lk.sel_end && lk.boundary) begin
			case (opc_ff)
			sfc_pkg::OPC_PERMIT_SET: wpl_set = is_tail;
			sfc_pkg::OPC_PERMIT_CLEAR: wpl_clr = is_tail;
			sfc_pkg::OPC_SLEEP_ENTRY: sleep_set = is_tail;
			sfc_pkg::OPC_SLEEP_EXIT: sleep_clr = is_tail;
			sfc_pkg::OPC_STATUS_UPDATE,
			sfc_pkg::OPC_LOCK_UPDATE: wpl_clr = is_data && wpl_ok;
			sfc_pkg::OPC_PAGE_REWRITE,
			sfc_pkg::OPC_PAGE_PROGRAM: start_page = is_data && wpl_ok;
			sfc_pkg::OPC_PAGE_WIPE: start_fill = is_tail && wpl_ok;
			sfc_pkg::OPC_SUB_WIPE: begin
				start_fill = is_tail && wpl_ok;
				fill_base = align_to(addr_ff[AW-1:0], sfc_pkg::SUB_BYTES);
				fill_span = span_of(sfc_pkg::SUB_BYTES);
			end
			sfc_pkg::OPC_SECT_WIPE: begin
				start_fill = is_tail && wpl_ok;
				fill_base = align_to(addr_ff[AW-1:0], sfc_pkg::SECT_BYTES);
				fill_span = span_of(sfc_pkg::SECT_BYTES);
			end
			sfc_pkg::OPC_ALL_WIPE: begin
				start_fill = is_tail && wpl_ok;
				fill_base = '0;
				fill_span = span_of(MEM_BYTES);
			end
			default: wpl_set = 1'b0;
			endcase
		end
	end

	// Set wins over a completion clear in the same cycle
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			wpl_ff <= 1'b0;
		end else if (CE) begin
			if (wpl_set) begin
				wpl_ff <= 1'b1;
			end else if (wpl_clr || ex_done) begin
				wpl_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			sleep_ff <= 1'b0;
		end else if (CE) begin
			if (sleep_set) begin
				sleep_ff <= 1'b1;
			end else if (sleep_clr) begin
				sleep_ff <= 1'b0;
			end
		end
	end

	// Internal cycle: one array byte per clock, so cycle length is the span
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			ex_state_ff <= sfc_pkg::EX_IDLE;
			ex_ptr_ff <= '0;
			ex_left_ff <= '0;
			ex_rewrite_ff <= 1'b0;
		end else if (CE) begin
			case (ex_state_ff)
			sfc_pkg::EX_IDLE: begin
				if (start_page) begin
					ex_state_ff <= sfc_pkg::EX_PAGE;
					ex_ptr_ff <= align_to(addr_ff[AW-1:0], sfc_pkg::PAGE_BYTES);
					ex_left_ff <= span_of(sfc_pkg::PAGE_BYTES);
					ex_rewrite_ff <= (opc_ff == sfc_pkg::OPC_PAGE_REWRITE);
				end else if (start_fill) begin
					ex_state_ff <= sfc_pkg::EX_FILL;
					ex_ptr_ff <= fill_base;
					ex_left_ff <= fill_span;
				end
			end
			sfc_pkg::EX_PAGE, sfc_pkg::EX_FILL: begin
				ex_ptr_ff <= ex_ptr_ff + AW'(1);
				ex_left_ff <= ex_left_ff - (AW+1)'(1);
				if (ex_done) begin
					ex_state_ff <= sfc_pkg::EX_IDLE;
				end
			end
			default: begin
				ex_state_ff <= sfc_pkg::EX_IDLE;
			end
			endcase
		end
	end

	assign ex_old = mem[ex_ptr_ff];
	assign ex_we = (ex_state_ff == sfc_pkg::EX_FILL) ||
		(ex_state_ff == sfc_pkg::EX_PAGE && page_mask_ff[ex_ptr_ff[7:0]]);

	always_comb begin
		if (ex_state_ff == sfc_pkg::EX_FILL) begin
			ex_new = sfc_pkg::ERASED_BYTE;
		end else if (ex_rewrite_ff) begin
			ex_new = page_buf[ex_ptr_ff[7:0]];
		end else begin
			ex_new = ex_old & page_buf[ex_ptr_ff[7:0]];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (CE && ex_we) begin
			mem[ex_ptr_ff] <= ex_new;
		end
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN || !CE);

	sequence s_last_addr(logic [7:0] op);
		state_ff == sfc_pkg::ST_ADDR && lk.rx_stb &&
			acnt_ff == sfc_pkg::LAST_ADDR_BYTE && opc_ff == op && !busy &&
			!lk.sel_start && !lk.sel_end;
	endsequence
	sequence s_bad_opcode;
		state_ff == sfc_pkg::ST_OPCODE && lk.rx_stb && !lk.sel_end &&
			nxt_after_opc == sfc_pkg::ST_IGNORE;
	endsequence

	AST_PROGRAM_CLEARS: assert property (
		ex_we && ex_state_ff == sfc_pkg::EX_PAGE && !ex_rewrite_ff |=>
		(mem[$past(ex_ptr_ff)] & ~$past(ex_old)) == 8'h00)
		else $error("program raised a bit from zero to one");
	AST_WIPE_ONES: assert property (
		ex_state_ff == sfc_pkg::EX_FILL |=>
		mem[$past(ex_ptr_ff)] == 8'hFF)
		else $error("wiped byte not all ones");
	AST_REWRITE_EXACT: assert property (
		ex_we && ex_state_ff == sfc_pkg::EX_PAGE && ex_rewrite_ff |=>
		mem[$past(ex_ptr_ff)] == $past(page_buf[ex_ptr_ff[7:0]]))
		else $error("rewritten byte differs from supplied data");
	AST_BOUNDARY_REJECT: assert property (
		lk.sel_end && !lk.boundary && !busy |=>
		!busy && $stable(wpl_ff) && $stable(sleep_ff))
		else $error("command executed without byte-boundary deselect");
	AST_PERMIT_NEEDED: assert property (
		$rose(busy) |-> $past(wpl_ff) && $past(lk.sel_end && lk.boundary))
		else $error("internal cycle started without write permit");
	AST_BUSY_NO_ARRAY_READ: assert property (
		busy && out_en_ff |-> opc_ff == sfc_pkg::OPC_STATUS_READ ||
		opc_ff == sfc_pkg::OPC_LOCK_READ)
		else $error("array output while internal cycle runs");
	AST_SUB_SPAN: assert property (
		start_fill && !busy && opc_ff == sfc_pkg::OPC_SUB_WIPE |=>
		ex_left_ff == (AW+1)'(sfc_pkg::SUB_BYTES) &&
		ex_ptr_ff[11:0] == 12'h000)
		else $error("subsector wipe span wrong");
	AST_SECT_SPAN: assert property (
		start_fill && !busy && opc_ff == sfc_pkg::OPC_SECT_WIPE |=>
		ex_left_ff == (AW+1)'(sfc_pkg::SECT_BYTES) &&
		ex_ptr_ff[15:0] == 16'h0000)
		else $error("sector wipe span wrong");
	AST_READ_OUTPUT: assert property (
		s_last_addr(sfc_pkg::OPC_READ) |=>
		state_ff == sfc_pkg::ST_DATA_OUT && out_en_ff)
		else $error("array read did not enter output after three bytes");
	AST_FAST_DUMMY: assert property (
		s_last_addr(sfc_pkg::OPC_FAST_READ) |=>
		state_ff == sfc_pkg::ST_DUMMY && !out_en_ff)
		else $error("fast read skipped its dummy byte");
	AST_UNKNOWN_QUIET: assert property (
		s_bad_opcode |=> state_ff == sfc_pkg::ST_IGNORE && !out_en_ff)
		else $error("unknown opcode not ignored");
endmodule : sfc_front_end

//--- sfc_host_model.sv
// Behavioural SPI host for the serial flash front end
`timescale 1ns/1ps
module sfc_host_model (
	input wire logic clk,
	input wire logic sdo,
	output logic sck,
	output logic cs_n,
	output logic sdi,
	output logic rd_stb,
	output logic [7:0] rd_byte
);
	// Phases above the 4-clock minimum, since the pins pass a synchroniser
	localparam int HALF = 6;
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
		rd_stb = 1'b0;
		rd_byte = 8'h00;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic bits(input int n, input logic [7:0] v,
		output logic [7:0] r);
		for (int i = 7; i > 7 - n; i--) begin
			sdi <= v[i];
			tick(HALF);
			sck <= 1'b1;
			r = {r[6:0], sdo};
			tick(HALF);
			sck <= 1'b0;
		end
	endtask : bits
	task automatic xfer(input logic [7:0] v, output logic [7:0] r);
		bits(8, v, r);
	endtask : xfer
	task automatic get();
		logic [7:0] r;
		xfer(8'($urandom), r);
		rd_byte <= r;
		rd_stb <= 1'b1;
		tick(1);
		rd_stb <= 1'b0;
	endtask : get
	task automatic sel();
		cs_n <= 1'b0;
		tick(HALF);
	endtask : sel
	task automatic desel();
		tick(HALF);
		cs_n <= 1'b1;
		// Released data line shows the inverse of its last bit
		sdi <= ~sdi;
		tick(8);
	endtask : desel
endmodule : sfc_host_model

//--- sfc_front_end_tb.sv
// Self-checking bench for the serial flash command front end
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
	$display("ERROR %0t got %h want %h", $time, a, b); end end
module sfc_front_end_tb;
	// Run needs about 13k clocks; the limit leaves ample margin
	localparam int LIMIT_NS = 400000;
	logic clk, rstn, ce, sck, cs_n, sdi, sdo, sdo_oe, busy, wp, slp;
	logic rd_stb;
	logic [7:0] rd_byte, e, d0, d1, p, r;
	logic [7:0] exp_q[$];
	int failures, check_count, oe_cnt, oe_base;
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	sfc_front_end DUT (.CLK_SYS(clk), .RSTN(rstn), .CE(ce), .SCK(sck),
		.CS_N(cs_n), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .BUSY(busy),
		.WRITE_PERMIT(wp), .SLEEPING(slp));
	sfc_host_model h (.clk(clk), .sdo(sdo), .sck(sck), .cs_n(cs_n),
		.sdi(sdi), .rd_stb(rd_stb), .rd_byte(rd_byte));
	always @(posedge clk) begin
		if (sdo_oe === 1'b1) oe_cnt++;
		if (rd_stb === 1'b1) begin
			if (exp_q.size() == 0) begin
				failures++;
				$display("ERROR %0t unexpected byte", $time);
			end else begin
				e = exp_q.pop_front();
				`CHK(rd_byte, e)
			end
		end
	end
	task automatic complete_run();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic cmd(input logic [7:0] op, input logic [23:0] a,
		input bit adr);
		h.sel();
		h.xfer(op, r);
		if (adr) for (int i = 2; i >= 0; i--) h.xfer(a[i*8 +: 8], r);
	endtask : cmd
	task automatic op(input logic [7:0] v);
		cmd(v, 24'h0, 1'b0);
		h.desel();
	endtask : op
	task automatic rd(input logic [7:0] v, input logic [23:0] a,
		input int n);
		cmd(v, a, 1'b1);
		if (v === sfc_pkg::OPC_FAST_READ) h.xfer(8'($urandom), r);
		repeat (n) h.get();
		h.desel();
	endtask : rd
	task automatic wait_idle();
		int n;
		n = 0;
		tick(6);
		while (busy !== 1'b0 && n < 70000) begin
			tick(1);
			n++;
		end
		if (n >= 70000) failures++;
	endtask : wait_idle
	task automatic rewrite(input logic [7:0] v);
		cmd(v, 24'h002000, 1'b1);
		h.xfer(d0, r);
		h.xfer(d1, r);
		h.desel();
	endtask : rewrite
	task automatic upd(input logic [7:0] v, input bit adr);
		op(sfc_pkg::OPC_PERMIT_SET);
		`CHK(wp, 1'b1)
		cmd(v, 24'h010000, adr);
		h.xfer(8'($urandom), r);
		h.desel();
	endtask : upd
	initial begin
		ce = 1'b1;
		rstn = 1'b0;
		void'($urandom(45549));
		d0 = 8'($urandom);
		d1 = 8'($urandom);
		p = 8'($urandom);
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		tick(4);
		`CHK({sdo_oe, busy, wp, slp}, 4'h0)
		op(sfc_pkg::OPC_PERMIT_SET);
		`CHK(wp, 1'b1)
		op(sfc_pkg::OPC_PERMIT_CLEAR);
		`CHK(wp, 1'b0)
		rewrite(sfc_pkg::OPC_PAGE_REWRITE);
		`CHK(busy, 1'b0)
		op(sfc_pkg::OPC_ALL_WIPE);
		`CHK(busy, 1'b0)
		h.sel();
		h.bits(7, sfc_pkg::OPC_PERMIT_SET, r);
		h.desel();
		`CHK(wp, 1'b0)
		op(sfc_pkg::OPC_PERMIT_SET);
		rewrite(sfc_pkg::OPC_PAGE_REWRITE);
		`CHK(busy, 1'b1)
		wait_idle();
		`CHK(wp, 1'b0)
		op(sfc_pkg::OPC_PERMIT_SET);
		cmd(sfc_pkg::OPC_PAGE_PROGRAM, 24'h002000, 1'b1);
		h.xfer(p, r);
		h.desel();
		wait_idle();
		op(sfc_pkg::OPC_PERMIT_SET);
		cmd(sfc_pkg::OPC_SUB_WIPE, 24'h001ABC, 1'b1);
		h.desel();
		exp_q.push_back(8'h03);
		exp_q.push_back(8'h03);
		cmd(sfc_pkg::OPC_STATUS_READ, 24'h0, 1'b0);
		repeat (2) h.get();
		h.desel();
		oe_base = oe_cnt;
		cmd(sfc_pkg::OPC_READ, 24'h002000, 1'b1);
		h.xfer(8'($urandom), r);
		h.desel();
		`CHK(oe_cnt - oe_base, 0)
		wait_idle();
		exp_q.push_back(sfc_pkg::ERASED_BYTE);
		exp_q.push_back(d0 & p);
		exp_q.push_back(d1);
		oe_base = oe_cnt;
		rd(sfc_pkg::OPC_READ, 24'h001FFF, 3);
		`CHK(oe_cnt > oe_base, 1'b1)
		exp_q.push_back(d1);
		rd(sfc_pkg::OPC_FAST_READ, 24'h002001, 1);
		exp_q.push_back(sfc_pkg::LOCK_READ_VAL);
		rd(sfc_pkg::OPC_LOCK_READ, 24'h000000, 1);
		upd(sfc_pkg::OPC_STATUS_UPDATE, 1'b0);
		`CHK(wp, 1'b0)
		upd(sfc_pkg::OPC_LOCK_UPDATE, 1'b1);
		`CHK(wp, 1'b0)
		op(sfc_pkg::OPC_PERMIT_SET);
		cmd(sfc_pkg::OPC_PAGE_WIPE, 24'h002000, 1'b1);
		h.desel();
		wait_idle();
		exp_q.push_back(sfc_pkg::ERASED_BYTE);
		rd(sfc_pkg::OPC_READ, 24'h002000, 1);
		op(sfc_pkg::OPC_SLEEP_ENTRY);
		`CHK(slp, 1'b1)
		op(sfc_pkg::OPC_PERMIT_SET);
		`CHK(wp, 1'b0)
		op(sfc_pkg::OPC_SLEEP_EXIT);
		`CHK(slp, 1'b0)
		oe_base = oe_cnt;
		cmd(8'h9F, 24'h0, 1'b0);
		repeat (2) h.xfer(8'($urandom), r);
		h.desel();
		`CHK(oe_cnt - oe_base, 0)
		op(sfc_pkg::OPC_PERMIT_SET);
		cmd(sfc_pkg::OPC_SECT_WIPE, 24'h034567, 1'b1);
		h.desel();
		`CHK(busy, 1'b1)
		rstn <= 1'b0;
		tick(2);
		rstn <= 1'b1;
		tick(2);
		`CHK({busy, wp, slp, sdo_oe}, 4'h0)
		`CHK(exp_q.size(), 0)
		complete_run();
	end
	initial begin
		#(LIMIT_NS * 1ns);
		failures++;
		complete_run();
	end
endmodule : sfc_front_end_tb
